// ===== rtl/tx_buffer_command_parser.v
/*
 * tx_buffer_command_parser: takes words written by the host to the data
 * port, splits them into command words a and b, offset, payload and
 * padding, and emits payload bytes toward the transmit fifo.
 * assumes a classic wishbone master on clk_in and a downstream fifo
 * that accepts a word per cycle when fifo_ready_in is high.
 */
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tx_cmd_regs.vh"

//////////////////////////////////////////////////////////////////////////
// Contract
// - each command is two 32-bit words, a then b
// - word b must match across buffers of a packet, else error flag
// - a 16-bit packet tag is taken from word b
// - the tag is passed unchanged with the packet's status; the code sends it on fifo_tag_out with each payload word instead
// - bit 31 of word a raises done once the buffer is loaded
// - done flag can reach the interrupt output under a mask
// - word a bits 25:24 select 4, 16 or 32 byte end alignment
// - padding words are dropped, never passed on
// - only payload goes to the fifo, not commands or padding
// - word a bits 20:16 give the first payload byte offset
// - bit 13 marks first segment, bit 12 last segment
// - byte counts summed per packet must equal word b length
module tx_buffer_command_parser #(
    parameter LEN_W = 16
) (
    input wire clk_in,
    input wire resetn_in,
    input wire ce_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    output reg wb_err_out,
    input wire fifo_ready_in,
    output reg [31:0] fifo_data_out,
    output reg [3:0] fifo_byte_en_out,
    output reg fifo_valid_out,
    output reg fifo_first_out,
    output reg fifo_last_out,
    output reg [15:0] fifo_tag_out,
    output reg irq_out
);

localparam ST_CMD_A = 2'h0;
localparam ST_CMD_B = 2'h1;
localparam ST_DATA = 2'h2;

//////////////////////////////////////////////////////////////////////////
// state

reg [1:0] state_r;
reg [31:0] cmd_a_r;
reg [31:0] cmd_b_r;
reg [31:0] pkt_b_r;
reg in_pkt_r;
reg [LEN_W-1:0] sum_r;
reg [11:0] word_idx_r;
reg [11:0] span_r;
reg [1:0] status_r;
reg [1:0] mask_r;
reg [15:0] pkt_count_r;
reg first_out_pending_r;

wire [11:0] span_w;

word_span u_span (
    .offset_in(cmd_a_r[`CMDA_OFS_HI:`CMDA_OFS_LO]),
    .size_in(cmd_a_r[`CMDA_SIZE_HI:`CMDA_SIZE_LO]),
    .align_in(cmd_a_r[`CMDA_ALIGN_HI:`CMDA_ALIGN_LO]),
    .words_out(span_w)
);

//////////////////////////////////////////////////////////////////////////
// bus decode

function hit;
    input [7:0] adr;
    input [7:0] reg_off;
    begin
        hit = (adr == reg_off);
    end
endfunction

wire req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
wire known = hit(wb_adr_in, `REG_DATA) | hit(wb_adr_in, `REG_STATUS) |
    hit(wb_adr_in, `REG_MASK) | hit(wb_adr_in, `REG_TAG) |
    hit(wb_adr_in, `REG_COUNT);
// data writes in ST_DATA stall while the held fifo word is not taken
wire data_wr = req & wb_we_in & hit(wb_adr_in, `REG_DATA);
wire stall = data_wr & (state_r == ST_DATA) & fifo_valid_out &
    ~fifo_ready_in;
wire take_data = data_wr & ~stall;

//////////////////////////////////////////////////////////////////////////
// byte window of the current payload word

wire [4:0] ofs = cmd_a_r[`CMDA_OFS_HI:`CMDA_OFS_LO];
wire [10:0] size = cmd_a_r[`CMDA_SIZE_HI:`CMDA_SIZE_LO];
wire [12:0] end_byte = {8'h00, ofs} + {2'b00, size};
wire [12:0] base = {word_idx_r[10:0], 2'b00};

function [3:0] lane_mask;
    input [12:0] b0;
    input [12:0] first_b;
    input [12:0] stop_b;
    integer i;
    reg [12:0] pos;
    begin
        lane_mask = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            pos = b0 + i[12:0];
            lane_mask[i] = (pos >= first_b) && (pos < stop_b);
        end
    end
endfunction

wire [3:0] lanes = lane_mask(base, {8'h00, ofs}, end_byte);
// span latched at word b so the count cannot move mid-buffer
wire last_word = (word_idx_r + 12'h001) >= span_r;
wire last_payload = (base + 13'h0004) >= end_byte;

//////////////////////////////////////////////////////////////////////////
// parser

wire [LEN_W-1:0] sum_nxt = (cmd_a_r[`CMDA_FIRST_BIT] ? {LEN_W{1'b0}} :
    sum_r) + {{(LEN_W-11){1'b0}}, size};
wire b_mismatch = in_pkt_r & ~cmd_a_r[`CMDA_FIRST_BIT] &
    (wb_dat_in != pkt_b_r);

reg set_done;
reg set_err;

always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        state_r <= ST_CMD_A;
        cmd_a_r <= 32'h0000_0000;
        cmd_b_r <= 32'h0000_0000;
        pkt_b_r <= 32'h0000_0000;
        in_pkt_r <= 1'b0;
        sum_r <= {LEN_W{1'b0}};
        word_idx_r <= 12'h000;
        span_r <= 12'h000;
        fifo_data_out <= 32'h0000_0000;
        fifo_byte_en_out <= 4'h0;
        fifo_valid_out <= 1'b0;
        fifo_first_out <= 1'b0;
        fifo_last_out <= 1'b0;
        fifo_tag_out <= 16'h0000;
        first_out_pending_r <= 1'b0;
        pkt_count_r <= 16'h0000;
        set_done <= 1'b0;
        set_err <= 1'b0;
    end else if (ce_in) begin
        set_done <= 1'b0;
        set_err <= 1'b0;
        if (fifo_valid_out && fifo_ready_in) begin
            fifo_valid_out <= 1'b0;
        end
        if (take_data) begin
            case (state_r)
                ST_CMD_A: begin
                    cmd_a_r <= wb_dat_in;
                    state_r <= ST_CMD_B;
                end
                ST_CMD_B: begin
                    cmd_b_r <= wb_dat_in;
                    if (cmd_a_r[`CMDA_FIRST_BIT] || !in_pkt_r) begin
                        pkt_b_r <= wb_dat_in;
                    end
                    if (b_mismatch) begin
                        set_err <= 1'b1;
                    end
                    in_pkt_r <= ~cmd_a_r[`CMDA_LAST_BIT];
                    first_out_pending_r <= cmd_a_r[`CMDA_FIRST_BIT];
                    sum_r <= sum_nxt;
                    if (cmd_a_r[`CMDA_LAST_BIT] &&
                        sum_nxt != wb_dat_in[`CMDB_LEN_HI:`CMDB_LEN_LO]) begin
                        set_err <= 1'b1;
                    end
                    word_idx_r <= 12'h000;
                    span_r <= span_w;
                    if (span_w == 12'h000) begin
                        state_r <= ST_CMD_A;
                        set_done <= cmd_a_r[`CMDA_IOC_BIT];
                    end else begin
                        state_r <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    // offset bytes and padding words never reach the fifo
                    if (lanes != 4'h0) begin
                        fifo_data_out <= wb_dat_in;
                        fifo_byte_en_out <= lanes;
                        fifo_valid_out <= 1'b1;
                        fifo_first_out <= first_out_pending_r;
                        fifo_last_out <= last_payload &
                            cmd_a_r[`CMDA_LAST_BIT];
                        fifo_tag_out <=
                            cmd_b_r[`CMDB_TAG_HI:`CMDB_TAG_LO];
                        first_out_pending_r <= 1'b0;
                        if (last_payload && cmd_a_r[`CMDA_LAST_BIT]) begin
                            pkt_count_r <= pkt_count_r + 16'h0001;
                        end
                    end
                    word_idx_r <= word_idx_r + 12'h001;
                    if (last_word) begin
                        state_r <= ST_CMD_A;
                        set_done <= cmd_a_r[`CMDA_IOC_BIT];
                    end
                end
                default: state_r <= ST_CMD_A;
            endcase
        end
    end
end

//////////////////////////////////////////////////////////////////////////
// status, mask, interrupt and bus answer

wire wr_status = req & wb_we_in & hit(wb_adr_in, `REG_STATUS) &
    wb_sel_in[0];
wire wr_mask = req & wb_we_in & hit(wb_adr_in, `REG_MASK) & wb_sel_in[0];
wire [1:0] events = {set_err, set_done};
// a new event wins over a same-cycle clear
wire [1:0] status_nxt = (status_r & ~(wr_status ? wb_dat_in[1:0] : 2'h0))
    | events;

always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        status_r <= `STATUS_RST;
        mask_r <= `MASK_RST;
        irq_out <= 1'b0;
        wb_ack_out <= 1'b0;
        wb_err_out <= 1'b0;
        wb_dat_out <= 32'h0000_0000;
    end else if (ce_in) begin
        status_r <= status_nxt;
        if (wr_mask) begin
            mask_r <= wb_dat_in[1:0];
        end
        irq_out <= |(status_nxt & (wr_mask ? wb_dat_in[1:0] : mask_r));
        wb_ack_out <= req & known & ~stall;
        wb_err_out <= req & ~known;
        wb_dat_out <= 32'h0000_0000;
        if (req && !wb_we_in) begin
            if (hit(wb_adr_in, `REG_STATUS)) begin
                wb_dat_out <= {30'h0000_0000, status_r};
            end else if (hit(wb_adr_in, `REG_MASK)) begin
                wb_dat_out <= {30'h0000_0000, mask_r};
            end else if (hit(wb_adr_in, `REG_TAG)) begin
                wb_dat_out <= {16'h0000, cmd_b_r[`CMDB_TAG_HI:`CMDB_TAG_LO]};
            end else if (hit(wb_adr_in, `REG_COUNT)) begin
                wb_dat_out <= {14'h0000, state_r, pkt_count_r};
            end
        end
    end
end

endmodule // tx_buffer_command_parser
`default_nettype wire

// ===== include/tx_cmd_regs.vh
/*
 * constants for the transmit command parser: command word fields,
 * alignment codes, wishbone register offsets and reset values.
 * assumes nothing; definitions only.
 */
`ifndef TX_CMD_REGS_VH
`define TX_CMD_REGS_VH

// command word a fields
`define CMDA_IOC_BIT 31
`define CMDA_ALIGN_HI 25
`define CMDA_ALIGN_LO 24
`define CMDA_OFS_HI 20
`define CMDA_OFS_LO 16
`define CMDA_FIRST_BIT 13
`define CMDA_LAST_BIT 12
`define CMDA_SIZE_HI 10
`define CMDA_SIZE_LO 0
// command word b fields
`define CMDB_TAG_HI 31
`define CMDB_TAG_LO 16
`define CMDB_LEN_HI 15
`define CMDB_LEN_LO 0

// end alignment codes
`define ALIGN_4 2'h0
`define ALIGN_16 2'h1
`define ALIGN_32 2'h2

// register byte offsets
`define REG_DATA 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_TAG 8'h0C
`define REG_COUNT 8'h10

// status and mask bit positions
`define ST_DONE_BIT 0
`define ST_ERR_BIT 1

// reset values
`define MASK_RST 2'h0
`define STATUS_RST 2'h0

`endif

// ===== rtl/word_span.v
/*
 * word_span: number of 32-bit words a buffer occupies after its command,
 * given start offset, byte count and end alignment code.
 * assumes a purely combinational use inside the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tx_cmd_regs.vh"

module word_span (
    input wire [4:0] offset_in,
    input wire [10:0] size_in,
    input wire [1:0] align_in,
    output wire [11:0] words_out
);

wire [11:0] bytes;
wire [9:0] raw_words;
reg [9:0] aligned;

assign bytes = {7'h00, offset_in} + {1'b0, size_in};
// round up to whole words
assign raw_words = bytes[11:2] + {9'h000, |bytes[1:0]};

always @* begin
    case (align_in)
        `ALIGN_16: aligned = (raw_words + 10'h003) & 10'h3FC;
        `ALIGN_32: aligned = (raw_words + 10'h007) & 10'h3F8;
        default: aligned = raw_words;
    endcase
end

assign words_out = {2'b00, aligned};

endmodule // word_span
`default_nettype wire

// ===== verification/tx_cmd_asserts.sv
/* port checker for tx_buffer_command_parser.
   assumes one clock, resetn_in async active low. */
`timescale 1ns/1ps
`default_nettype none
`include "tx_cmd_regs.vh"
module tx_cmd_asserts (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic wb_ack_out,
    input wire logic wb_err_out,
    input wire logic fifo_ready_in,
    input wire logic [31:0] fifo_data_out,
    input wire logic [3:0] fifo_byte_en_out,
    input wire logic fifo_valid_out,
    input wire logic [15:0] fifo_tag_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_rd_req; $rose(wb_cyc_in && wb_stb_in) && !wb_we_in; endsequence
    sequence s_answer; wb_ack_out || wb_err_out; endsequence
    property p_rd_lat; s_rd_req |=> s_answer; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; $rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    // a stalled word must not change under the consumer
    property p_hold; fifo_valid_out && !fifo_ready_in |=> fifo_valid_out &&
        $stable(fifo_data_out) && $stable(fifo_tag_out); endproperty
    a_hold: assert property (p_hold) else $error("word moved");
    property p_src; fifo_valid_out && !$past(fifo_valid_out && !fifo_ready_in)
        |-> wb_ack_out && $past(wb_we_in) && $past(wb_adr_in) == `REG_DATA;
    endproperty
    a_src: assert property (p_src) else $error("word not from data");
    property p_be; fifo_valid_out |-> fifo_byte_en_out != 4'h0; endproperty
    a_be: assert property (p_be) else $error("empty word");
    property p_irq_rise; $rose(irq_out) |-> $past(wb_ack_out) || wb_ack_out;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose");
    property p_irq_fall; $fell(irq_out) |-> $past(wb_ack_out) || wb_ack_out;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
endmodule // tx_cmd_asserts
bind tx_buffer_command_parser tx_cmd_asserts chk (.clk_in, .resetn_in,
    .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_ack_out, .wb_err_out,
    .fifo_ready_in, .fifo_data_out, .fifo_byte_en_out, .fifo_valid_out,
    .fifo_tag_out, .irq_out);
`default_nettype wire

// ===== verification/fifo_sink.sv
/* downstream fifo model: logs accepted words.
   assumes one clock; stall_in makes ready toggle. */
`timescale 1ns/1ps
`default_nettype none
module fifo_sink (
    input wire logic clk_in,
    input wire logic stall_in,
    input wire logic valid_in,
    input wire logic [31:0] data_in,
    input wire logic [3:0] be_in,
    input wire logic first_in,
    input wire logic last_in,
    input wire logic [15:0] tag_in,
    output logic ready_out
);
    logic [53:0] got[$];
    initial ready_out = 1'b1;
    always @(posedge clk_in) begin
        if (valid_in && ready_out)
            got.push_back({first_in, last_in, tag_in, be_in, data_in});
        ready_out <= stall_in ? !ready_out : 1'b1;
    end
endmodule // fifo_sink
`default_nettype wire

// ===== verification/tx_buffer_command_parser_tb.sv
/* bench for tx_buffer_command_parser.
   assumes fifo_sink downstream and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "tx_cmd_regs.vh"
module tx_buffer_command_parser_tb;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic req = 1'b0;
    logic wb_we_in = 1'b0;
    logic stall = 1'b0;
    logic e;
    logic [7:0] wb_adr_in = 8'h00;
    logic [31:0] wb_dat_in = 32'h0000_0000;
    logic [31:0] rd;
    wire [31:0] wb_dat_out, fifo_data_out;
    wire [15:0] fifo_tag_out;
    wire [3:0] fifo_byte_en_out;
    wire wb_ack_out, wb_err_out, fifo_ready_in, fifo_valid_out;
    wire fifo_first_out, fifo_last_out, irq_out;
    int n_mismatch = 0;
    int checked = 0;
    int pw[3] = '{1, 4, 8};
    initial forever #2.5 clk_in = ~clk_in;
    tx_buffer_command_parser DUT (.clk_in, .resetn_in, .ce_in(1'b1),
        .wb_cyc_in(req), .wb_stb_in(req), .wb_we_in, .wb_adr_in,
        .wb_sel_in(4'hf), .wb_dat_in, .wb_dat_out, .wb_ack_out, .wb_err_out,
        .fifo_ready_in, .fifo_data_out, .fifo_byte_en_out, .fifo_valid_out,
        .fifo_first_out, .fifo_last_out, .fifo_tag_out, .irq_out);
    fifo_sink sink (.clk_in, .stall_in(stall), .valid_in(fifo_valid_out),
        .data_in(fifo_data_out), .be_in(fifo_byte_en_out),
        .first_in(fifo_first_out), .last_in(fifo_last_out),
        .tag_in(fifo_tag_out), .ready_out(fifo_ready_in));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // data writes may stall behind the fifo, so no fixed latency
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int i;
        @(posedge clk_in);
        req <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= a;
        wb_dat_in <= d;
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (!(wb_ack_out || wb_err_out) && i < 50);
        if (i >= 50) begin
            n_mismatch++;
            stop_test;
        end
        rd = wb_dat_out;
        e = wb_err_out;
        req <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, x);
    endtask
    task automatic blk(input logic [31:0] a, b, input int n);
        wr(`REG_DATA, a);
        wr(`REG_DATA, b);
        for (int i = 0; i < n; i++)
            wr(`REG_DATA, 32'h1000_0000 + i);
    endtask
    task automatic pkt2(input logic [31:0] b1, b2);
        blk(32'h0000_2004, b1, 1);
        blk(32'h0000_1004, b2, 1);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        rdchk(`REG_STATUS, 32'h0000_0000);
        rdchk(`REG_MASK, 32'h0000_0000);
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk(e, 1'b1);
        $display("test reset done");
        stall <= 1'b1;
        wr(`REG_MASK, 32'h0000_0001);
        blk(32'h8101_3005, 32'h1234_0005, 4);
        settle(4);
        chk(sink.got.size(), 2);
        chk(sink.got[0], {2'b10, 16'h1234, 4'he, 32'h1000_0000});
        chk(sink.got[1], {2'b01, 16'h1234, 4'h3, 32'h1000_0001});
        chk(irq_out, 1'b1);
        wr(`REG_MASK, 32'h0000_0000);
        settle(1);
        chk(irq_out, 1'b0);
        rdchk(`REG_STATUS, 32'h0000_0001);
        wr(`REG_STATUS, 32'h0000_0001);
        rdchk(`REG_STATUS, 32'h0000_0000);
        $display("test done flag done");
        stall <= 1'b0;
        for (int c = 0; c < 3; c++) begin
            blk({6'h00, c[1:0], 24'h00_3004}, 32'h0100_0004, pw[c]);
            settle(3);
            chk(sink.got.size(), 3 + c);
            chk(sink.got[2 + c], {2'b11, 16'h0100, 4'hf, 32'h1000_0000});
        end
        $display("test alignment done");
        pkt2(32'h0055_0008, 32'h0055_0008);
        rdchk(`REG_STATUS, 32'h0000_0000);
        pkt2(32'h0055_0008, 32'h0056_0008);
        rdchk(`REG_STATUS, 32'h0000_0002);
        wr(`REG_STATUS, 32'h0000_0002);
        blk(32'h0000_3004, 32'h0057_0006, 1);
        rdchk(`REG_STATUS, 32'h0000_0002);
        rdchk(`REG_TAG, 32'h0000_0057);
        rdchk(`REG_COUNT, 32'h0000_0007);
        rdchk(`REG_DATA, 32'h0000_0000);
        $display("test packet checks done");
        stop_test;
    end
endmodule // tx_buffer_command_parser_tb
`default_nettype wire
